/* File: design/gpx_pkg.sv */
// Package of register map, field layout and types for the pin port block
package gpx_pkg;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] GPX_IDX_A_VALUE = 8'h00;
	localparam logic [7:0] GPX_IDX_A_DIR = 8'h01;
	localparam logic [7:0] GPX_IDX_A_OPT = 8'h02;
	localparam logic [7:0] GPX_IDX_B_VALUE = 8'h04;
	localparam logic [7:0] GPX_IDX_B_DIR = 8'h05;
	localparam logic [7:0] GPX_IDX_B_OPT = 8'h06;
	localparam logic [7:0] GPX_IDX_MISC = 8'h20;
	localparam logic [7:0] GPX_IDX_IRQ_STATUS = 8'h21;
	localparam logic [7:0] GPX_IDX_IRQ_MASK = 8'h22;
	localparam int GPX_ADDR_SHIFT = 2;
	localparam int GPX_PADDR_W = 10;

	// ==========================================================
	// Reset values
	localparam logic [7:0] GPX_RST_BYTE = 8'h00;
	localparam logic [1:0] GPX_RST_IRQ = 2'h0;

	// ==========================================================
	// Miscellaneous configuration fields
	localparam int GPX_MISC_PCLK_BIT = 7;
	localparam int GPX_MISC_SSRC_BIT = 6;
	localparam int GPX_MISC_SSLVL_BIT = 5;
	localparam int GPX_MISC_SENSB_HI = 4;
	localparam int GPX_MISC_SENSB_LO = 3;
	localparam int GPX_MISC_SENSA_HI = 2;
	localparam int GPX_MISC_SENSA_LO = 1;
	localparam int GPX_MISC_SLOW_BIT = 0;

	// ==========================================================
	// Interrupt status and mask bits
	localparam int GPX_IRQ_A_BIT = 0;
	localparam int GPX_IRQ_B_BIT = 1;

	// ==========================================================
	// Clock dividers, ratios of the oscillator
	localparam logic [4:0] GPX_DIV2_MAX = 5'h01;
	localparam logic [4:0] GPX_DIV4_MAX = 5'h03;
	localparam logic [4:0] GPX_DIV32_MAX = 5'h1F;
	localparam int GPX_SHARED_SELECT_BIT = 2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		GPX_SENS_FALL_LOW = 2'b00,
		GPX_SENS_RISE = 2'b01,
		GPX_SENS_FALL = 2'b10,
		GPX_SENS_BOTH = 2'b11
	} gpx_sens_t;

	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe_b;
		logic [7:0] pull_up;
	} gpx_pins_t;

	typedef struct packed {
		logic periph_tick;
		logic cpu_tick;
		logic periph_div4;
		logic cpu_slow;
	} gpx_clocks_t;
endpackage

/* File: design/gpx_ports.sv */
// Two pin ports with external interrupt groups and misc configuration
//
// Function
// - Every software write updates the value latch, even for input pins.
// - Value read gives latch for outputs, synchronised pin level for inputs.
// - Direction bit zero makes pin input, one makes it output.
// - Input pin option zero is floating, one pull-up and interrupt capable.
// - Output pin option zero is open drain, one push-pull where supported.
// - Pins without option bit drive as option zero: open drain output, floating input, no pull-up; option one still joins interrupt group.
// - Reset clears value, direction and option registers of both ports.
// - Config bit 7 picks peripheral clock oscillator/2 or /4.
// - Config bit 6 picks slave select from pin or internal bit 5.
// - With internal slave select, shared pin stays ordinary port pin.
// - Config bits 4:3 set port B interrupt sensitivity.
// - Config bits 2:1 set port A interrupt sensitivity, same codes.
// - Sensitivity fields are written only while CPU interrupt mask set.
// - Config bit 0 picks CPU clock oscillator/2 or slow /32.
// - Input with option one raises group request on selected event.
// - Enabled pins of a group combine by AND; one low masks others.
// - Pending request clears on vector fetch unless set again in that cycle (low level held), and always on sensitivity change.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module gpx_ports
	import gpx_pkg::*;
#(
	parameter logic [7:0] A_OPT_IMPL = 8'hFF,
	parameter logic [7:0] B_OPT_IMPL = 8'h38,
	parameter logic [7:0] B_PIN_IMPL = 8'h3F
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [GPX_PADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// CPU side
	input wire logic cpu_flags_i_mask_in,
	input wire logic group_a_vector_fetch_in,
	input wire logic group_b_vector_fetch_in,
	output logic group_a_interrupt_out,
	output logic group_b_interrupt_out,
	output logic irq_out,
	// Pins
	input wire logic [7:0] port_a_pins_in,
	input wire logic [7:0] port_b_pins_in,
	output gpx_pins_t port_a_pins_out,
	output gpx_pins_t port_b_pins_out,
	// Peripheral side
	output logic slave_select_level_out,
	output gpx_clocks_t clocks_out
);
	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [GPX_PADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == (GPX_PADDR_W'(idx) << GPX_ADDR_SHIFT));
	endfunction

	function automatic logic [7:0] pin_read(input logic [7:0] lat, input logic [7:0] dir,
		input logic [7:0] lvl);
		pin_read = (lat & dir) | (lvl & ~dir);
	endfunction

	logic [7:0] a_val_reg, a_dir_reg, a_opt_reg;
	logic [7:0] b_val_reg, b_dir_reg, b_opt_reg;
	logic [7:0] misc_reg;
	logic [1:0] status_reg, mask_reg;
	logic [7:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
	logic [1:0] comb_prev_reg, pend_reg;
	logic [4:0] div_cnt_reg;
	logic [31:0] prdata_reg;
	logic slverr_reg;
	logic wr_en, rd_setup, mapped;
	logic [7:0] wbyte, rd_byte, misc_next;
	logic [1:0] comb_now, fall, rise, pend_set, pend_clr, sens_chg;
	gpx_sens_t sens [2];

	assign wr_en = ce_in & psel_in & penable_in & pwrite_in;
	assign rd_setup = ce_in & psel_in & ~penable_in;
	assign wbyte = pwdata_in[7:0];

	// ==========================================================
	// Port registers
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			a_val_reg <= GPX_RST_BYTE;
			a_dir_reg <= GPX_RST_BYTE;
			a_opt_reg <= GPX_RST_BYTE;
			b_val_reg <= GPX_RST_BYTE;
			b_dir_reg <= GPX_RST_BYTE;
			b_opt_reg <= GPX_RST_BYTE;
		end else if (wr_en) begin
			if (hit(paddr_in, GPX_IDX_A_VALUE)) a_val_reg <= wbyte;
			if (hit(paddr_in, GPX_IDX_A_DIR)) a_dir_reg <= wbyte;
			if (hit(paddr_in, GPX_IDX_A_OPT)) a_opt_reg <= wbyte;
			if (hit(paddr_in, GPX_IDX_B_VALUE)) b_val_reg <= wbyte & B_PIN_IMPL;
			if (hit(paddr_in, GPX_IDX_B_DIR)) b_dir_reg <= wbyte & B_PIN_IMPL;
			if (hit(paddr_in, GPX_IDX_B_OPT)) b_opt_reg <= wbyte & B_PIN_IMPL;
		end
	end

	// ==========================================================
	// Miscellaneous configuration
	always_comb begin
		misc_next = wbyte;
		if (!cpu_flags_i_mask_in) begin
			misc_next[GPX_MISC_SENSB_HI:GPX_MISC_SENSB_LO] =
				misc_reg[GPX_MISC_SENSB_HI:GPX_MISC_SENSB_LO];
			misc_next[GPX_MISC_SENSA_HI:GPX_MISC_SENSA_LO] =
				misc_reg[GPX_MISC_SENSA_HI:GPX_MISC_SENSA_LO];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			misc_reg <= GPX_RST_BYTE;
		end else if (wr_en && hit(paddr_in, GPX_IDX_MISC)) begin
			misc_reg <= misc_next;
		end
	end

	assign sens[0] = gpx_sens_t'(misc_reg[GPX_MISC_SENSA_HI:GPX_MISC_SENSA_LO]);
	assign sens[1] = gpx_sens_t'(misc_reg[GPX_MISC_SENSB_HI:GPX_MISC_SENSB_LO]);
	assign sens_chg[0] = wr_en & hit(paddr_in, GPX_IDX_MISC) &
		(misc_next[GPX_MISC_SENSA_HI:GPX_MISC_SENSA_LO] != sens[0]);
	assign sens_chg[1] = wr_en & hit(paddr_in, GPX_IDX_MISC) &
		(misc_next[GPX_MISC_SENSB_HI:GPX_MISC_SENSB_LO] != sens[1]);

	// ==========================================================
	// Pin drivers
	always_comb begin
		port_a_pins_out.level = a_val_reg;
		port_a_pins_out.oe_b = ~(a_dir_reg & ((a_opt_reg & A_OPT_IMPL) | ~a_val_reg));
		port_a_pins_out.pull_up = ~a_dir_reg & a_opt_reg & A_OPT_IMPL;
		port_b_pins_out.level = b_val_reg;
		port_b_pins_out.oe_b = ~(b_dir_reg & ((b_opt_reg & B_OPT_IMPL) | ~b_val_reg));
		port_b_pins_out.pull_up = ~b_dir_reg & b_opt_reg & B_OPT_IMPL;
	end

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			a_s1_reg <= GPX_RST_BYTE;
			a_s2_reg <= GPX_RST_BYTE;
			b_s1_reg <= GPX_RST_BYTE;
			b_s2_reg <= GPX_RST_BYTE;
		end else if (ce_in) begin
			a_s1_reg <= port_a_pins_in;
			a_s2_reg <= a_s1_reg;
			b_s1_reg <= port_b_pins_in;
			b_s2_reg <= b_s1_reg;
		end
	end

	// ==========================================================
	// Slave select source
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			slave_select_level_out <= 1'b0;
		end else if (ce_in) begin
			slave_select_level_out <= misc_reg[GPX_MISC_SSRC_BIT] ?
				misc_reg[GPX_MISC_SSLVL_BIT] : b_s2_reg[GPX_SHARED_SELECT_BIT];
		end
	end

	// ==========================================================
	// External interrupt groups
	assign comb_now[0] = &(a_s2_reg | a_dir_reg | ~a_opt_reg);
	assign comb_now[1] = &(b_s2_reg | b_dir_reg | ~b_opt_reg | ~B_PIN_IMPL);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : grp
			assign fall[g] = comb_prev_reg[g] & ~comb_now[g];
			assign rise[g] = ~comb_prev_reg[g] & comb_now[g];
			always_comb begin
				case (sens[g])
					GPX_SENS_FALL_LOW: pend_set[g] = fall[g] | ~comb_now[g];
					GPX_SENS_RISE: pend_set[g] = rise[g];
					GPX_SENS_FALL: pend_set[g] = fall[g];
					GPX_SENS_BOTH: pend_set[g] = fall[g] | rise[g];
					default: pend_set[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	assign pend_clr = {group_b_vector_fetch_in, group_a_vector_fetch_in};

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			comb_prev_reg <= 2'h3;
			pend_reg <= GPX_RST_IRQ;
		end else if (ce_in) begin
			comb_prev_reg <= comb_now;
			pend_reg <= (pend_set | (pend_reg & ~pend_clr)) & ~sens_chg;
		end
	end

	assign group_a_interrupt_out = pend_reg[GPX_IRQ_A_BIT];
	assign group_b_interrupt_out = pend_reg[GPX_IRQ_B_BIT];

	// ==========================================================
	// Sticky status and mask
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status_reg <= GPX_RST_IRQ;
			mask_reg <= GPX_RST_IRQ;
		end else if (ce_in) begin
			if (wr_en && hit(paddr_in, GPX_IDX_IRQ_STATUS)) begin
				status_reg <= (status_reg & ~wbyte[1:0]) | (pend_set & ~sens_chg);
			end else begin
				status_reg <= status_reg | (pend_set & ~sens_chg);
			end
			if (wr_en && hit(paddr_in, GPX_IDX_IRQ_MASK)) mask_reg <= wbyte[1:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_out <= 1'b0;
		end else if (ce_in) begin
			irq_out <= |(status_reg & mask_reg);
		end
	end

	// ==========================================================
	// Clock dividers
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_cnt_reg <= 5'h00;
			clocks_out <= '0;
		end else if (ce_in) begin
			div_cnt_reg <= div_cnt_reg + 5'h01;
			clocks_out.periph_div4 <= misc_reg[GPX_MISC_PCLK_BIT];
			clocks_out.cpu_slow <= misc_reg[GPX_MISC_SLOW_BIT];
			clocks_out.periph_tick <= misc_reg[GPX_MISC_PCLK_BIT] ?
				((div_cnt_reg & GPX_DIV4_MAX) == GPX_DIV4_MAX) :
				((div_cnt_reg & GPX_DIV2_MAX) == GPX_DIV2_MAX);
			clocks_out.cpu_tick <= misc_reg[GPX_MISC_SLOW_BIT] ?
				(div_cnt_reg == GPX_DIV32_MAX) :
				((div_cnt_reg & GPX_DIV2_MAX) == GPX_DIV2_MAX);
		end
	end

	// ==========================================================
	// APB read path
	always_comb begin
		rd_byte = 8'h00;
		mapped = 1'b1;
		if (hit(paddr_in, GPX_IDX_A_VALUE)) rd_byte = pin_read(a_val_reg, a_dir_reg, a_s2_reg);
		else if (hit(paddr_in, GPX_IDX_A_DIR)) rd_byte = a_dir_reg;
		else if (hit(paddr_in, GPX_IDX_A_OPT)) rd_byte = a_opt_reg;
		else if (hit(paddr_in, GPX_IDX_B_VALUE)) rd_byte = pin_read(b_val_reg, b_dir_reg,
			b_s2_reg & B_PIN_IMPL);
		else if (hit(paddr_in, GPX_IDX_B_DIR)) rd_byte = b_dir_reg;
		else if (hit(paddr_in, GPX_IDX_B_OPT)) rd_byte = b_opt_reg;
		else if (hit(paddr_in, GPX_IDX_MISC)) rd_byte = misc_reg;
		else if (hit(paddr_in, GPX_IDX_IRQ_STATUS)) rd_byte = {6'h00, status_reg};
		else if (hit(paddr_in, GPX_IDX_IRQ_MASK)) rd_byte = {6'h00, mask_reg};
		else mapped = 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end else if (rd_setup) begin
			prdata_reg <= {24'h000000, rd_byte};
			slverr_reg <= ~mapped;
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = psel_in & penable_in & ce_in;
	assign pslverr_out = pready_out & slverr_reg;
endmodule
`default_nettype wire

/* File: sim/gpx_pin_model.sv */
// Pin world model resolving each port pin level
`timescale 1ns/1ps
`default_nettype none
module gpx_pin_model
	import gpx_pkg::*;
(
	// Clock
	input wire logic clk_in,
	// Device pins and outside driver
	input wire gpx_pins_t pins_in,
	input wire logic [7:0] ext_in,
	input wire logic [7:0] drv_in,
	output logic [7:0] level_out
);
	logic [7:0] flt_reg = 8'h00;
	always_ff @(posedge clk_in) begin
		flt_reg <= ~level_out;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pins_in.oe_b[i]) begin
				level_out[i] = pins_in.level[i];
			end else if (drv_in[i]) begin
				level_out[i] = ext_in[i];
			end else if (pins_in.pull_up[i]) begin
				level_out[i] = 1'b1;
			end else begin
				level_out[i] = flt_reg[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/gpx_ports_monitor.sv */
// Checker of port relations of the pin port block
`timescale 1ns/1ps
`default_nettype none
module gpx_ports_monitor
	import gpx_pkg::*;
(
	// Clock, reset, APB
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [GPX_PADDR_W-1:0] paddr_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// Interrupt, pins, clocks
	input wire logic group_a_vector_fetch_in,
	input wire logic group_a_interrupt_out,
	input wire logic irq_out,
	input wire gpx_pins_t port_a_pins_out,
	input wire gpx_pins_t port_b_pins_out,
	input wire gpx_clocks_t clocks_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// =====
	// Assertions
	reset_val_a: assert property ($rose(rst_b_in) |-> port_a_pins_out == 24'h00FF00
		&& port_b_pins_out == 24'h00FF00) else $error("pins not reset");
	pend_hold_a: assert property (group_a_interrupt_out && !group_a_vector_fetch_in
		&& !(psel_in && pwrite_in && paddr_in == 10'h080) |=> group_a_interrupt_out)
		else $error("pending lost");
	drive_od_a: assert property ((~port_b_pins_out.oe_b[2:0] & port_b_pins_out.level[2:0])
		== 3'h0) else $error("true open drain drives high");
	pull_in_a: assert property ((port_a_pins_out.pull_up & ~port_a_pins_out.oe_b)
		== 8'h00) else $error("pull-up on driven pin");
	err_ready_a: assert property (pslverr_out |-> pready_out) else $error("error without ready");
	ready_now_a: assert property (psel_in && !penable_in && ce_in ##1 penable_in && ce_in
		|-> pready_out) else $error("wait state");
	ptick_div2_a: assert property (disable iff (!rst_b_in || !ce_in)
		ce_in && clocks_out.periph_tick && !clocks_out.periph_div4
		|-> ##2 (clocks_out.periph_tick || clocks_out.periph_div4)) else $error("div2 tick");
	ptick_div4_a: assert property (disable iff (!rst_b_in || !ce_in)
		ce_in && clocks_out.periph_tick && clocks_out.periph_div4 |=>
		(!clocks_out.periph_tick || !clocks_out.periph_div4)[*3]) else $error("div4 tick");
	ctick_slow_a: assert property (disable iff (!rst_b_in || !ce_in)
		ce_in && clocks_out.cpu_tick && clocks_out.cpu_slow |=>
		(!clocks_out.cpu_tick || !clocks_out.cpu_slow)[*8]) else $error("slow tick");
	// =====
	// Covers
	c_fetch: cover property (group_a_interrupt_out && group_a_vector_fetch_in);
	c_irq: cover property (irq_out);
	c_err: cover property (pslverr_out);
endmodule
bind gpx_ports gpx_ports_monitor i_gpx_ports_monitor (.clk_in, .rst_b_in, .ce_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .pready_out, .pslverr_out, .group_a_vector_fetch_in,
	.group_a_interrupt_out, .irq_out, .port_a_pins_out, .port_b_pins_out, .clocks_out);
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking testbench of the pin port block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gpx_pkg::*;
	logic clk_in, rst_b_in, ce_in, psel_in, penable_in, pwrite_in, mask_f, fa, fb;
	logic [GPX_PADDR_W-1:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out;
	logic pready_out, pslverr_out, ga, gb, irq_out, ss;
	logic [7:0] a_in, b_in, a_ext, b_ext, a_drv, b_drv;
	gpx_pins_t a_out, b_out;
	gpx_clocks_t clocks_out;
	int n_fail, check_count;
	gpx_ports i_gpx_ports (.clk_in, .rst_b_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.cpu_flags_i_mask_in(mask_f), .group_a_vector_fetch_in(fa),
		.group_b_vector_fetch_in(fb), .group_a_interrupt_out(ga), .group_b_interrupt_out(gb),
		.irq_out, .port_a_pins_in(a_in), .port_b_pins_in(b_in), .port_a_pins_out(a_out),
		.port_b_pins_out(b_out), .slave_select_level_out(ss), .clocks_out);
	gpx_pin_model i_pa (.clk_in, .pins_in(a_out), .ext_in(a_ext), .drv_in(a_drv), .level_out(a_in));
	gpx_pin_model i_pb (.clk_in, .pins_in(b_out), .ext_in(b_ext), .drv_in(b_drv), .level_out(b_in));
	// =====
	// Shared tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= GPX_PADDR_W'({idx, 2'b00});
		pwdata_in <= {24'h0, d};
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			report_and_stop();
		end else begin
			r = prdata_out;
			e = pslverr_out;
			psel_in <= 1'b0;
			penable_in <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(nm, x, r);
	endtask
	task automatic setpin(input int g, input logic v);
		if (g == 1) b_ext[3] <= v;
		else a_ext[0] <= v;
	endtask
	task automatic fetch(input int g);
		@(posedge clk_in);
		if (g == 1) fb <= 1'b1;
		else fa <= 1'b1;
		@(posedge clk_in);
		fa <= 1'b0;
		fb <= 1'b0;
	endtask
	// =====
	// Scenarios
	task automatic t_reset;
		logic [7:0] ix[9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h20, 8'h21, 8'h22};
		logic [31:0] r;
		logic e;
		foreach (ix[i]) rdc("reset value", ix[i], 32'h0);
		apb(1'b0, 8'h03, 8'h00, r, e);
		chk("unmapped error", 32'h1, e);
	endtask
	task automatic t_latch;
		a_ext <= 8'h3C;
		wr(GPX_IDX_A_VALUE, 8'hA5);
		cyc(4);
		rdc("input read", GPX_IDX_A_VALUE, 32'h3C);
		chk("latch", 32'hA5, a_out.level);
		wr(GPX_IDX_A_DIR, 8'hF0);
		cyc(4);
		rdc("mixed read", GPX_IDX_A_VALUE, 32'hAC);
		chk("open drain", 32'hAF, a_out.oe_b);
		wr(GPX_IDX_A_OPT, 8'hFF);
		cyc(1);
		chk("push pull", 32'h0F, a_out.oe_b);
		chk("pull up", 32'h0F, a_out.pull_up);
		wr(GPX_IDX_B_DIR, 8'h07);
		wr(GPX_IDX_B_OPT, 8'hFF);
		wr(GPX_IDX_B_VALUE, 8'h05);
		cyc(1);
		chk("b drive", 32'hFD, b_out.oe_b);
		chk("b pull", 32'h38, b_out.pull_up);
		wr(GPX_IDX_B_DIR, 8'h00);
		wr(GPX_IDX_A_DIR, 8'h00);
	endtask
	task automatic t_misc;
		wr(GPX_IDX_MISC, 8'hFF);
		cyc(3);
		rdc("misc locked", GPX_IDX_MISC, 32'hE1);
		chk("dividers", 32'h3, {clocks_out.periph_div4, clocks_out.cpu_slow});
		chk("internal select", 32'h1, ss);
		wr(GPX_IDX_B_VALUE, 8'h01);
		wr(GPX_IDX_B_DIR, 8'h04);
		cyc(1);
		chk("shared pin", 32'h0, b_out.oe_b[2]);
		chk("shared level", 32'h0, b_out.level[2]);
		wr(GPX_IDX_B_DIR, 8'h00);
		mask_f <= 1'b1;
		b_ext <= 8'h04;
		wr(GPX_IDX_MISC, 8'h1E);
		cyc(4);
		rdc("misc open", GPX_IDX_MISC, 32'h1E);
		chk("pin select", 32'h1, ss);
		chk("dividers", 32'h0, {clocks_out.periph_div4, clocks_out.cpu_slow});
	endtask
	task automatic t_irq;
		logic [1:0] m;
		logic s0;
		wr(GPX_IDX_A_OPT, 8'h01);
		wr(GPX_IDX_B_OPT, 8'h08);
		for (int g = 0; g < 2; g++) begin
			for (int k = 0; k < 8; k++) begin
				m = k[2:1];
				s0 = k[0];
				wr(GPX_IDX_MISC, 8'(m) << (g == 1 ? 3 : 1));
				setpin(g, s0);
				cyc(6);
				fetch(g);
				cyc(6);
				chk("level pend", m == 2'b00 && !s0, g == 1 ? gb : ga);
				setpin(g, !s0);
				cyc(6);
				chk("edge pend", (m == 2'b00 && !s0) || (s0 ? m != 2'b01 : m[0]),
					g == 1 ? gb : ga);
				fetch(g);
				cyc(6);
				chk("fetch clear", m == 2'b00 && s0, g == 1 ? gb : ga);
			end
		end
		setpin(0, 1'b1);
		setpin(1, 1'b1);
		cyc(6);
		wr(GPX_IDX_IRQ_STATUS, 8'h03);
		rdc("status clear", GPX_IDX_IRQ_STATUS, 32'h0);
		setpin(0, 1'b0);
		cyc(6);
		rdc("status set", GPX_IDX_IRQ_STATUS, 32'h1);
		chk("irq masked", 32'h0, irq_out);
		wr(GPX_IDX_IRQ_MASK, 8'h01);
		cyc(3);
		chk("irq on", 32'h1, irq_out);
		setpin(0, 1'b1);
		cyc(6);
		wr(GPX_IDX_MISC, 8'h1A);
		cyc(1);
		chk("sens clear", 32'h0, ga);
		wr(GPX_IDX_IRQ_STATUS, 8'h01);
		cyc(3);
		chk("irq off", 32'h0, irq_out);
	endtask
	// =====
	// Clock enable freeze
	task automatic t_freeze;
		ce_in <= 1'b0;
		setpin(0, 1'b0);
		cyc(4);
		setpin(0, 1'b1);
		cyc(4);
		ce_in <= 1'b1;
		cyc(6);
		chk("frozen pend", 32'h0, ga);
		rdc("frozen status", GPX_IDX_IRQ_STATUS, 32'h0);
		setpin(0, 1'b0);
		cyc(6);
		setpin(0, 1'b1);
		cyc(6);
		rdc("live status", GPX_IDX_IRQ_STATUS, 32'h1);
		chk("live irq", 32'h1, irq_out);
	endtask
	// =====
	// Clock and main sequence
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		rst_b_in = 1'b0;
		ce_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = '0;
		pwdata_in = 32'h0;
		mask_f = 1'b0;
		fa = 1'b0;
		fb = 1'b0;
		a_ext = 8'h00;
		b_ext = 8'h00;
		a_drv = 8'hFF;
		b_drv = 8'hFF;
		n_fail = 0;
		check_count = 0;
		cyc(2);
		rst_b_in <= 1'b1;
		t_reset();
		t_latch();
		t_misc();
		t_irq();
		t_freeze();
		report_and_stop();
	end
endmodule
`default_nettype wire
